// ---- hdl/pan_pkg.sv ----
// Package of constants and the carrier type for the autoneg register set.
package pan_pkg;

  // ****************************************
  // Register indices; the byte address is the index times four
  // ****************************************
  localparam logic [7:0] PAN_IDX_IDENT = 8'h03;
  localparam logic [7:0] PAN_IDX_ADV = 8'h04;
  localparam logic [7:0] PAN_IDX_PART = 8'h05;
  localparam logic [7:0] PAN_IDX_EXP = 8'h06;
  localparam logic [7:0] PAN_IDX_NPTX = 8'h07;
  localparam logic [7:0] PAN_IDX_NPRX = 8'h08;
  localparam logic [7:0] PAN_IDX_CTRL = 8'h10;
  localparam logic [7:0] PAN_IDX_PAGE = 8'h1F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PAN_NP_BIT = 15;
  localparam int PAN_ACK_BIT = 14;
  localparam int PAN_RF_BIT = 13;
  localparam int PAN_MP_BIT = 13;
  localparam int PAN_WC_BIT = 12;
  localparam int PAN_TOG_BIT = 11;
  localparam int PAN_EXP_PDF_BIT = 4;
  localparam int PAN_EXP_LPNP_BIT = 3;
  localparam int PAN_EXP_NPA_BIT = 2;
  localparam int PAN_EXP_PR_BIT = 1;
  localparam int PAN_EXP_LPAN_BIT = 0;
  localparam int PAN_CTRL_RESTART_BIT = 9;

  // ****************************************
  // Reset values and fixed codes
  // ****************************************
  // Value is arbitrary, not tied to any real maker.
  localparam logic [5:0] PAN_ORG_ID_BITS = 6'h2A;
  // Value is arbitrary, not tied to any real maker.
  localparam logic [5:0] PAN_MODEL_RST = 6'h15;
  localparam logic [15:0] PAN_ADV_RST = 16'h01E1;
  localparam logic [15:0] PAN_NPTX_RST = 16'h2001;
  localparam logic [15:0] PAN_ADV_WMASK = 16'hADFF;
  localparam logic [15:0] PAN_NPTX_WMASK = 16'hB7FF;
  localparam logic [1:0] PAN_PAGE_MAX = 2'h2;

  // ****************************************
  // Carrier of one received link code word
  // ****************************************
  typedef struct packed {
    logic valid;
    logic base;
    logic [15:0] word;
  } pan_lcw_t;

endpackage : pan_pkg

// ---- hdl/pan_regs.sv ----
// Autoneg register set with an APB slave and link code word ports.
`timescale 1ns/10ps
module pan_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap of silicon revision
  input wire logic [3:0] silicon_rev,
  // Autoneg engine
  input wire pan_pkg::pan_lcw_t rx_lcw,
  input wire logic tx_page_sent,
  input wire logic par_det_fault,
  input wire logic partner_an_able,
  output logic [15:0] adv_word,
  output logic [15:0] np_tx_word,
  output logic an_restart
);
  import pan_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0] idx;
  logic hit_ok;
  logic wr_en;
  logic rd_en;
  logic page_ok;
  logic [1:0] page_q;
  logic [15:0] rdata_d;

  assign idx = paddr[9:2];
  assign pready = 1'b1;
  // Pages 0 to 2 share one copy of each register.
  assign page_ok = (page_q <= PAN_PAGE_MAX);
  always_comb begin
    hit_ok = 1'b0;
    case (idx)
      PAN_IDX_IDENT, PAN_IDX_ADV, PAN_IDX_PART, PAN_IDX_EXP,
      PAN_IDX_NPTX, PAN_IDX_NPRX: hit_ok = page_ok;
      PAN_IDX_CTRL, PAN_IDX_PAGE: hit_ok = 1'b1;
      default: hit_ok = 1'b0;
    endcase
  end
  assign wr_en = psel && penable && pwrite && hit_ok;
  assign rd_en = psel && penable && !pwrite && hit_ok;
  assign pslverr = psel && penable && !hit_ok;

  // ****************************************
  // Registers
  // ****************************************
  logic [5:0] model_q;
  logic [3:0] rev_q;
  logic rev_loaded_q;
  logic [15:0] adv_q;
  logic [15:0] part_q;
  logic part_asym_q;
  logic pdf_q;
  logic pr_q;
  logic lpnp_q;
  logic [15:0] nptx_q;
  logic last_tog_q;
  logic [15:0] nprx_q;
  logic restart_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= 2'h0;
    end else if (wr_en && idx == PAN_IDX_PAGE) begin
      page_q <= pwdata[1:0];
    end
  end

  // The strap is a pin, so it crosses two flops before any use.
  logic [3:0] rev_s1_q;
  logic [3:0] rev_s2_q;
  logic [1:0] rev_wait_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_s1_q <= 4'h0;
      rev_s2_q <= 4'h0;
    end else begin
      rev_s1_q <= silicon_rev;
      rev_s2_q <= rev_s1_q;
    end
  end

  // Loading waits until the second flop holds the strap, two edges in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_wait_q <= 2'h0;
    end else if (rev_wait_q != 2'h2) begin
      rev_wait_q <= rev_wait_q + 2'h1;
    end
  end

  // Revision is caught once the strap has crossed; earlier writes are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      model_q <= PAN_MODEL_RST;
      rev_q <= 4'h0;
      rev_loaded_q <= 1'b0;
    end else if (!rev_loaded_q) begin
      if (rev_wait_q == 2'h2) begin
        rev_q <= rev_s2_q;
        rev_loaded_q <= 1'b1;
      end
    end else if (wr_en && idx == PAN_IDX_IDENT) begin
      model_q <= pwdata[9:4];
      rev_q <= pwdata[3:0];
    end
  end

  // Reserved bits are masked so they stay zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_q <= PAN_ADV_RST;
    end else if (wr_en && idx == PAN_IDX_ADV) begin
      adv_q <= pwdata[15:0] & PAN_ADV_WMASK;
    end
  end
  assign adv_word = adv_q;

  // A base page updates the partner word; bit 11 may also be written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_q <= 16'h0000;
      part_asym_q <= 1'b0;
      lpnp_q <= 1'b0;
    end else if (rx_lcw.valid && rx_lcw.base) begin
      part_q <= rx_lcw.word & 16'hA7FF;
      part_q[PAN_ACK_BIT] <= 1'b1;
      part_asym_q <= rx_lcw.word[PAN_TOG_BIT];
      lpnp_q <= rx_lcw.word[PAN_NP_BIT];
    end else if (wr_en && idx == PAN_IDX_PART) begin
      part_asym_q <= pwdata[PAN_TOG_BIT];
    end
  end

  // Set wins over a clear-on-read in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_q <= 1'b0;
      pr_q <= 1'b0;
    end else begin
      if (par_det_fault) begin
        pdf_q <= 1'b1;
      end else if (rd_en && idx == PAN_IDX_EXP) begin
        pdf_q <= 1'b0;
      end
      if (rx_lcw.valid) begin
        pr_q <= 1'b1;
      end else if (rd_en && idx == PAN_IDX_EXP) begin
        pr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nptx_q <= PAN_NPTX_RST;
    end else if (wr_en && idx == PAN_IDX_NPTX) begin
      nptx_q <= pwdata[15:0] & PAN_NPTX_WMASK;
    end
  end

  // Toggle tracks the word last sent; reported bit is its inverse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_tog_q <= 1'b1;
    end else if (tx_page_sent) begin
      last_tog_q <= np_tx_word[PAN_TOG_BIT];
    end
  end
  always_comb begin
    np_tx_word = nptx_q;
    np_tx_word[PAN_TOG_BIT] = !last_tog_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nprx_q <= 16'h0000;
    end else if (rx_lcw.valid && !rx_lcw.base) begin
      nprx_q <= rx_lcw.word;
    end
  end

  // Restart is a one-cycle pulse; the control bit never holds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_en && idx == PAN_IDX_CTRL &&
                   pwdata[PAN_CTRL_RESTART_BIT];
    end
  end
  assign an_restart = restart_q;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdata_d = 16'h0000;
    case (idx)
      PAN_IDX_IDENT: rdata_d = {PAN_ORG_ID_BITS, model_q, rev_q};
      PAN_IDX_ADV: rdata_d = adv_q;
      PAN_IDX_PART: begin
        rdata_d = part_q;
        rdata_d[PAN_TOG_BIT] = part_asym_q;
      end
      PAN_IDX_EXP: begin
        rdata_d[PAN_EXP_PDF_BIT] = pdf_q;
        rdata_d[PAN_EXP_LPNP_BIT] = lpnp_q;
        rdata_d[PAN_EXP_NPA_BIT] = 1'b1;
        rdata_d[PAN_EXP_PR_BIT] = pr_q;
        rdata_d[PAN_EXP_LPAN_BIT] = partner_an_able;
      end
      PAN_IDX_NPTX: rdata_d = np_tx_word;
      PAN_IDX_NPRX: rdata_d = nprx_q;
      PAN_IDX_PAGE: rdata_d = {14'h0000, page_q};
      default: rdata_d = 16'h0000;
    endcase
  end
  assign prdata = hit_ok ? {16'h0000, rdata_d} : 32'h0000_0000;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_restart_req;
    wr_en && idx == PAN_IDX_CTRL && pwdata[PAN_CTRL_RESTART_BIT];
  endsequence

  sequence s_single_pulse;
    an_restart ##1 !an_restart;
  endsequence

  property p_restart_pulse;
    @(posedge pclk) disable iff (!presetn)
      s_restart_req |=> s_single_pulse;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart not a single pulse");

  property p_pr_set;
    @(posedge pclk) disable iff (!presetn) rx_lcw.valid |=> pr_q;
  endproperty
  a_pr_set: assert property (p_pr_set)
    else $error("page received not latched");

  property p_pdf_hold;
    @(posedge pclk) disable iff (!presetn)
      (pdf_q && !(rd_en && idx == PAN_IDX_EXP)) |=> pdf_q;
  endproperty
  a_pdf_hold: assert property (p_pdf_hold)
    else $error("fault flag dropped without read");

  property p_nprx_load;
    @(posedge pclk) disable iff (!presetn)
      (rx_lcw.valid && !rx_lcw.base) |=> nprx_q == $past(rx_lcw.word);
  endproperty
  a_nprx_load: assert property (p_nprx_load)
    else $error("next page word not captured");

  property p_ack_set;
    @(posedge pclk) disable iff (!presetn)
      (rx_lcw.valid && rx_lcw.base) |=> part_q[PAN_ACK_BIT];
  endproperty
  a_ack_set: assert property (p_ack_set)
    else $error("partner ack not set");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
      tx_page_sent |=> np_tx_word[PAN_TOG_BIT] != $past(np_tx_word[11]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not invert");

  property p_ident_org;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && idx == PAN_IDX_IDENT) |-> prdata[15:10] == PAN_ORG_ID_BITS;
  endproperty
  a_ident_org: assert property (p_ident_org)
    else $error("organization bits wrong");

  property p_np_able;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && idx == PAN_IDX_EXP) |-> prdata[PAN_EXP_NPA_BIT];
  endproperty
  a_np_able: assert property (p_np_able)
    else $error("next page able not one");

  property p_pdf_set;
    @(posedge pclk) disable iff (!presetn)
      par_det_fault |=> pdf_q;
  endproperty
  a_pdf_set: assert property (p_pdf_set)
    else $error("fault flag not latched");

  property p_pr_hold;
    @(posedge pclk) disable iff (!presetn)
      (pr_q && !(rd_en && idx == PAN_IDX_EXP)) |=> pr_q;
  endproperty
  a_pr_hold: assert property (p_pr_hold)
    else $error("page received dropped without read");

  property p_pr_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && idx == PAN_IDX_EXP && !rx_lcw.valid) |=> !pr_q;
  endproperty
  a_pr_clear: assert property (p_pr_clear)
    else $error("page received not cleared by read");

  property p_pdf_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && idx == PAN_IDX_EXP && !par_det_fault) |=> !pdf_q;
  endproperty
  a_pdf_clear: assert property (p_pdf_clear)
    else $error("fault flag not cleared by read");

  property p_part_hold;
    @(posedge pclk) disable iff (!presetn)
      !(rx_lcw.valid && rx_lcw.base) |=> $stable(part_q);
  endproperty
  a_part_hold: assert property (p_part_hold)
    else $error("partner word changed without base page");

  property p_nprx_hold;
    @(posedge pclk) disable iff (!presetn)
      !(rx_lcw.valid && !rx_lcw.base) |=> $stable(nprx_q);
  endproperty
  a_nprx_hold: assert property (p_nprx_hold)
    else $error("next page word changed without page");

  property p_adv_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == PAN_IDX_ADV)
      |=> adv_q == ($past(pwdata[15:0]) & PAN_ADV_WMASK);
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advertisement write not taken");

  property p_nptx_rsv;
    @(posedge pclk) disable iff (!presetn)
      (nptx_q & ~PAN_NPTX_WMASK) == 16'h0000;
  endproperty
  a_nptx_rsv: assert property (p_nptx_rsv)
    else $error("next page reserved bits set");

  property p_err_zero;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");

  property p_page_refused;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && page_q > PAN_PAGE_MAX && idx == PAN_IDX_PART)
      |-> pslverr;
  endproperty
  a_page_refused: assert property (p_page_refused)
    else $error("access on bad page not refused");

  property p_rev_hold;
    @(posedge pclk) disable iff (!presetn)
      (rev_loaded_q && !(wr_en && idx == PAN_IDX_IDENT)) |=> $stable(rev_q);
  endproperty
  a_rev_hold: assert property (p_rev_hold)
    else $error("revision changed without write");

endmodule // pan_regs

// ---- sim/pan_engine_model.sv ----
// Behavioural model of the autoneg engine and the remote link partner.
`timescale 1ns/10ps
module pan_engine_model (
  // Clock
  input wire logic pclk,
  // Engine side of the register set
  output pan_pkg::pan_lcw_t rx_lcw,
  output logic tx_page_sent,
  output logic par_det_fault,
  output logic partner_an_able
);
  import pan_pkg::*;

  initial begin
    rx_lcw = '0;
    tx_page_sent = 1'b0;
    par_det_fault = 1'b0;
    partner_an_able = 1'b0;
  end

  // The word is inverted once valid drops so no stale copy can be caught.
  task automatic send_page(input logic base, input logic [15:0] w);
    rx_lcw <= '{valid: 1'b1, base: base, word: w};
    @(posedge pclk);
    rx_lcw <= '{valid: 1'b0, base: base, word: ~w};
  endtask

  task automatic set_an_able(input logic v);
    partner_an_able <= v;
  endtask

  task automatic pulse_tx();
    tx_page_sent <= 1'b1;
    @(posedge pclk);
    tx_page_sent <= 1'b0;
  endtask

  task automatic pulse_fault();
    par_det_fault <= 1'b1;
    @(posedge pclk);
    par_det_fault <= 1'b0;
  endtask
endmodule // pan_engine_model

// ---- sim/pan_regs_bench.sv ----
// Self-checking bench for the autoneg register set.
`timescale 1ns/10ps
module pan_regs_bench;
  import pan_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, an_restart, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] silicon_rev;
  logic [15:0] adv_word, np_tx_word, rd, w, part;
  pan_lcw_t rx_lcw;
  logic tx_page_sent, par_det_fault, partner_an_able;
  int bad_count = 0, n_compared = 0, seed = 37, seen, restart_seen = 0;

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (an_restart === 1'b1) restart_seen++;
  end

  pan_regs pan_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .silicon_rev(silicon_rev), .rx_lcw(rx_lcw),
    .tx_page_sent(tx_page_sent), .par_det_fault(par_det_fault),
    .partner_an_able(partner_an_able), .adv_word(adv_word),
    .np_tx_word(np_tx_word), .an_restart(an_restart));
  pan_engine_model pan_engine_model_inst (.pclk(pclk), .rx_lcw(rx_lcw),
    .tx_page_sent(tx_page_sent), .par_det_fault(par_det_fault),
    .partner_an_able(partner_an_able));

  // ****
  // Bus cycles and comparisons
  // ****
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [15:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[15:0];
    err = pslverr;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("FAIL pready expected 1 seen %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] e);
    apb(1'b0, idx, 16'h0000);
    chk($sformatf("reg %h", idx), e, rd);
  endtask

  function automatic logic [15:0] exp_word(input logic pr, input logic pdf);
    return {11'h000, pdf, part[15], 1'b1, pr, partner_an_able};
  endfunction

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    silicon_rev = 4'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(PAN_IDX_IDENT, {PAN_ORG_ID_BITS, PAN_MODEL_RST, silicon_rev});
    rdchk(PAN_IDX_ADV, 16'h01E1);
    rdchk(PAN_IDX_PART, 16'h0000);
    rdchk(PAN_IDX_EXP, 16'h0004);
    rdchk(PAN_IDX_NPTX, 16'h2001);
    rdchk(PAN_IDX_NPRX, 16'h0000);
    $display("test reset values done");
    w = 16'($random(seed));
    apb(1'b1, PAN_IDX_IDENT, w);
    rdchk(PAN_IDX_IDENT, {PAN_ORG_ID_BITS, w[9:0]});
    apb(1'b1, PAN_IDX_ADV, w);
    rdchk(PAN_IDX_ADV, w & 16'hADFF);
    chk("adv_word", w & 16'hADFF, adv_word);
    apb(1'b1, PAN_IDX_NPTX, ~w);
    rdchk(PAN_IDX_NPTX, ~w & 16'hB7FF);
    chk("np_tx_word", ~w & 16'hB7FF, np_tx_word);
    for (int i = 1; i <= 2; i++) begin
      pan_engine_model_inst.pulse_tx();
      rdchk(PAN_IDX_NPTX, (~w & 16'hB7FF) | 16'((i % 2) << 11));
    end
    $display("test writes and toggle done");
    pan_engine_model_inst.set_an_able(1'b1);
    repeat (3) begin
      w = 16'($random(seed));
      part = (w & 16'hAFFF) | 16'h4000;
      pan_engine_model_inst.send_page(1'b1, w);
      rdchk(PAN_IDX_PART, part);
      rdchk(PAN_IDX_EXP, exp_word(1'b1, 1'b0));
      rdchk(PAN_IDX_EXP, exp_word(1'b0, 1'b0));
      w = 16'($random(seed));
      pan_engine_model_inst.send_page(1'b0, w);
      rdchk(PAN_IDX_NPRX, w);
      rdchk(PAN_IDX_PART, part);
      rdchk(PAN_IDX_EXP, exp_word(1'b1, 1'b0));
    end
    pan_engine_model_inst.pulse_fault();
    rdchk(PAN_IDX_EXP, exp_word(1'b0, 1'b1));
    rdchk(PAN_IDX_EXP, exp_word(1'b0, 1'b0));
    $display("test partner pages done");
    seen = restart_seen;
    apb(1'b1, PAN_IDX_CTRL, 16'h0200);
    repeat (4) @(posedge pclk);
    chk("restart pulses", 16'd1, 16'(restart_seen - seen));
    rdchk(PAN_IDX_CTRL, 16'h0000);
    for (int p = 1; p <= 3; p++) begin
      apb(1'b1, PAN_IDX_PAGE, 16'(p));
      apb(1'b0, PAN_IDX_PART, 16'h0000);
      chk("paged read", (p == 3) ? 16'h0000 : part, rd);
      chk("paged err", 16'(p == 3), 16'(err));
    end
    apb(1'b1, PAN_IDX_PAGE, 16'h0000);
    apb(1'b0, 8'h0B, 16'h0000);
    chk("unmapped err", 16'h0001, 16'(err));
    $display("test restart and pages done");
    tally_and_finish();
  end
endmodule // pan_regs_bench
